// *** logic/srd_simd_datapath.sv ***
`timescale 1ns/100ps
module srd_simd_datapath import srd_pkg::*; (
   // clock and reset
   input wire logic mclk_i,
   input wire logic rst_i,
   // control
   input wire logic [1:0] cur_round_mode_i,
   input wire logic align_check_i,
   // operation request
   input wire srd_req_s req_i,
   // result
   output srd_res_s res_o
);
   srd_res_s state_r;
   srd_res_s state_nxt;
   logic [SRD_VW-1:0] rnd_s;
   logic [SRD_VW-1:0] rnd_d;
   logic [3:0] inx_s;
   logic [1:0] inx_d;
   logic [1:0] mode;

   function automatic logic [SRD_SW-1:0] get_el(input logic [SRD_VW-1:0] v,
                                                input logic [1:0] sz,
                                                input logic [3:0] idx);
      logic [6:0] sh;
      logic [SRD_SW-1:0] m;
      sh = {idx & (4'hF >> sz), 3'h0} << sz;
      m = {SRD_SW{1'b1}} >> (7'(SRD_SW) - (7'h8 << sz));
      return SRD_SW'(v >> sh) & m;
   endfunction : get_el

   function automatic logic [SRD_VW-1:0] put_el(input logic [SRD_VW-1:0] v,
                                                input logic [1:0] sz,
                                                input logic [3:0] idx,
                                                input logic [SRD_SW-1:0] x);
      logic [6:0] sh;
      logic [SRD_VW-1:0] m;
      sh = {idx & (4'hF >> sz), 3'h0} << sz;
      m = SRD_VW'({SRD_SW{1'b1}} >> (7'(SRD_SW) - (7'h8 << sz))) << sh;
      return (v & ~m) | ((SRD_VW'(x) << sh) & m);
   endfunction : put_el

   // misaligned for a reference of 1 << lg bytes
   function automatic logic misal(input logic [3:0] addr, input logic [2:0] lg);
      return (addr & 4'((5'h1 << lg) - 5'h1)) != 4'h0;
   endfunction : misal

   function automatic logic [SRD_VW-1:0] widen(input logic [SRD_SW-1:0] src,
                                               input logic [1:0] s,
                                               input logic [1:0] d,
                                               input logic sx);
      logic [SRD_VW-1:0] r;
      logic [SRD_SW-1:0] el;
      logic [SRD_SW-1:0] ms;
      logic [SRD_SW-1:0] md;
      r = '0;
      ms = {SRD_SW{1'b1}} >> (7'(SRD_SW) - (7'h8 << s));
      md = {SRD_SW{1'b1}} >> (7'(SRD_SW) - (7'h8 << d));
      for (int j = 0; j < 8; j++) begin
         if (j < (16 >> d)) begin
            el = (src >> (j * (8 << s))) & ms;
            if (sx && el[(8 << s) - 1]) el = el | ~ms;
            r = r | (SRD_VW'(el & md) << (j * (8 << d)));
         end
      end
      return r;
   endfunction : widen

   assign mode = req_i.imm[SRD_IMM_CUR] ? cur_round_mode_i : req_i.imm[1:0];

   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_single
         srd_round_lane #(.EW(8), .MW(23)) u_lane (
            .opnd_i(req_i.b[32*g +: 32]),
            .mode_i(mode),
            .res_o(rnd_s[32*g +: 32]),
            .inexact_o(inx_s[g])
         );
      end
      for (g = 0; g < 2; g++) begin : g_double
         srd_round_lane #(.EW(11), .MW(52)) u_lane (
            .opnd_i(req_i.b[64*g +: 64]),
            .mode_i(mode),
            .res_o(rnd_d[64*g +: 64]),
            .inexact_o(inx_d[g])
         );
      end
   endgenerate

   always_comb begin
      logic [15:0] sum;
      logic [7:0] x;
      logic [7:0] y;
      logic [15:0] mv;
      logic [2:0] mi;
      logic [31:0] dw;
      logic [2:0] lg;
      logic [3:0] bo;
      logic [3:0] so;
      sum = '0;
      x = '0;
      y = '0;
      mv = '0;
      mi = '0;
      dw = '0;
      lg = '0;
      bo = '0;
      so = '0;
      state_nxt = '0;
      state_nxt.valid = req_i.valid;
      state_nxt.vec = req_i.a;
      unique case (req_i.op)
         SRD_ROUND_PACKED_SINGLE: begin
            state_nxt.vec = rnd_s;
            state_nxt.inexact = |inx_s;
            state_nxt.vec_wr = 1'b1;
         end
         SRD_ROUND_PACKED_DOUBLE: begin
            state_nxt.vec = rnd_d;
            state_nxt.inexact = |inx_d;
            state_nxt.vec_wr = 1'b1;
         end
         SRD_ROUND_SCALAR_SINGLE: begin
            state_nxt.vec[31:0] = rnd_s[31:0];
            state_nxt.inexact = inx_s[0];
            state_nxt.vec_wr = 1'b1;
         end
         SRD_ROUND_SCALAR_DOUBLE: begin
            state_nxt.vec[63:0] = rnd_d[63:0];
            state_nxt.inexact = inx_d[0];
            state_nxt.vec_wr = 1'b1;
         end
         SRD_EXTRACT_SINGLE_FLOAT: begin
            state_nxt.scl = get_el(req_i.a, SRD_SZ_D, {2'h0, req_i.imm[1:0]});
            state_nxt.align_fault = req_i.mem && align_check_i && misal(req_i.addr_lo, 3'h2);
            state_nxt.mem_wr = req_i.mem;
            state_nxt.gpr_wr = ~req_i.mem;
         end
         SRD_INSERT_SINGLE_FLOAT: begin
            dw = req_i.mem ? req_i.scl[31:0]
               : 32'(get_el(req_i.b, SRD_SZ_D, {2'h0, req_i.imm[SRD_IMM_SRC +: 2]}));
            state_nxt.vec = put_el(req_i.a, SRD_SZ_D, {2'h0, req_i.imm[SRD_IMM_DST +: 2]}, SRD_SW'(dw));
            for (int j = 0; j < 4; j++) begin
               if (req_i.imm[j]) state_nxt.vec[32*j +: 32] = '0;
            end
            state_nxt.align_fault = req_i.mem && align_check_i && misal(req_i.addr_lo, 3'h2);
            state_nxt.vec_wr = 1'b1;
         end
         SRD_INSERT_INT: begin
            state_nxt.vec = put_el(req_i.a, req_i.esz, req_i.imm[3:0], req_i.scl);
            state_nxt.align_fault = req_i.mem && align_check_i && misal(req_i.addr_lo, {1'b0, req_i.esz});
            state_nxt.vec_wr = 1'b1;
         end
         SRD_EXTRACT_INT: begin
            state_nxt.scl = get_el(req_i.a, req_i.esz, req_i.imm[3:0]);
            state_nxt.align_fault = req_i.mem && align_check_i && misal(req_i.addr_lo, {1'b0, req_i.esz});
            state_nxt.mem_wr = req_i.mem;
            state_nxt.gpr_wr = ~req_i.mem;
         end
         SRD_WIDEN: begin
            state_nxt.vec = widen(req_i.mem ? req_i.scl : req_i.b[63:0], req_i.esz, req_i.dsz, req_i.sext);
            lg = 3'(4 - req_i.dsz + req_i.esz);
            state_nxt.align_fault = req_i.mem && align_check_i && misal(req_i.addr_lo, lg);
            state_nxt.vec_wr = 1'b1;
         end
         SRD_MULTI_OFFSET_ABS_DIFF_SUM: begin
            bo = {req_i.imm[SRD_IMM_DOFF], 2'h0};
            so = {req_i.imm[1:0], 2'h0};
            for (int i = 0; i < 8; i++) begin
               sum = '0;
               for (int k = 0; k < 4; k++) begin
                  x = req_i.a[8*(bo + 4'(i + k)) +: 8];
                  y = req_i.b[8*(so + 4'(k)) +: 8];
                  sum = sum + 16'((x > y) ? (x - y) : (y - x));
               end
               state_nxt.vec[16*i +: 16] = sum;
            end
            state_nxt.vec_wr = 1'b1;
         end
         SRD_HORIZONTAL_MIN_SEARCH: begin
            mv = req_i.b[15:0];
            for (int i = 1; i < 8; i++) begin
               if (req_i.b[16*i +: 16] < mv) begin
                  mv = req_i.b[16*i +: 16];
                  mi = 3'(i);
               end
            end
            state_nxt.vec = '0;
            state_nxt.vec[15:0] = mv;
            state_nxt.vec[SRD_MIN_POS +: 3] = mi;
            state_nxt.vec_wr = 1'b1;
         end
         SRD_PACKED_MASK_TEST: begin
            state_nxt.zero_flag = (req_i.a & req_i.b) == '0;
            state_nxt.carry_flag = (req_i.a & ~req_i.b) == '0;
            state_nxt.flag_wr = 1'b1;
         end
         SRD_QWORD_EQUALITY_COMPARE: begin
            for (int i = 0; i < 2; i++) begin
               state_nxt.vec[64*i +: 64] = {64{req_i.a[64*i +: 64] == req_i.b[64*i +: 64]}};
            end
            state_nxt.vec_wr = 1'b1;
         end
         SRD_DWORD_EQUALITY_COMPARE: begin
            for (int i = 0; i < 4; i++) begin
               state_nxt.vec[32*i +: 32] = {32{req_i.a[32*i +: 32] == req_i.b[32*i +: 32]}};
            end
            state_nxt.vec_wr = 1'b1;
         end
         SRD_PACK_DWORD_WORD_UNSIGNED_SAT: begin
            for (int i = 0; i < 8; i++) begin
               dw = (i < 4) ? req_i.a[32*i +: 32] : req_i.b[32*(i%4) +: 32];
               if (dw[31]) state_nxt.vec[16*i +: 16] = '0;
               else if (dw[31:16] != '0) state_nxt.vec[16*i +: 16] = SRD_SAT_MAX;
               else state_nxt.vec[16*i +: 16] = dw[15:0];
            end
            state_nxt.vec_wr = 1'b1;
         end
         default: begin
         end
      endcase
      if (req_i.imm[SRD_IMM_QUIET] && req_i.op inside {SRD_ROUND_PACKED_SINGLE, SRD_ROUND_PACKED_DOUBLE,
                                                        SRD_ROUND_SCALAR_SINGLE, SRD_ROUND_SCALAR_DOUBLE}) begin
         state_nxt.inexact = 1'b0;
      end
      // a fault cancels every write
      if (state_nxt.align_fault) begin
         state_nxt.vec_wr = 1'b0;
         state_nxt.gpr_wr = 1'b0;
         state_nxt.mem_wr = 1'b0;
      end
      if (!req_i.valid) state_nxt = '0;
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) state_r <= '0;
      else state_r <= state_nxt;
   end

   assign res_o = state_r;

   default clocking @(posedge mclk_i); endclocking
   default disable iff (rst_i);

   let s_req(o) = req_i.valid && req_i.op == o;

   a_round_trunc_mode: assert property (
      s_req(SRD_ROUND_SCALAR_SINGLE) && !req_i.imm[SRD_IMM_CUR] && req_i.imm[1:0] == SRD_RM_TRUNC
      && req_i.b[31:0] == 32'h40200000 |=> res_o.vec[31:0] == 32'h40000000)
      else $error("truncate mode result wrong");
   a_round_quiet_bit: assert property (
      s_req(SRD_ROUND_PACKED_DOUBLE) && req_i.imm[SRD_IMM_QUIET] |=> res_o.valid && !res_o.inexact)
      else $error("inexact not suppressed");
   a_round_scalar_keep: assert property (
      s_req(SRD_ROUND_SCALAR_DOUBLE) |=> res_o.vec[127:64] == $past(req_i.a[127:64]))
      else $error("scalar round changed upper lane");
   a_insert_no_align: assert property (
      s_req(SRD_INSERT_INT) && !align_check_i |=> !res_o.align_fault && res_o.vec_wr)
      else $error("insert faulted without checking");
   a_extract_fp_lane: assert property (
      s_req(SRD_EXTRACT_SINGLE_FLOAT) |=>
      res_o.scl[31:0] == 32'($past(req_i.a) >> (32 * $past(req_i.imm[1:0]))))
      else $error("float extract lane wrong");
   a_insert_zero_mask: assert property (
      s_req(SRD_INSERT_SINGLE_FLOAT) && req_i.imm[0] |=> res_o.vec[31:0] == 32'h00000000)
      else $error("zero mask ignored");
   a_widen_fault_odd: assert property (
      s_req(SRD_WIDEN) && req_i.mem && align_check_i && req_i.addr_lo[0] |=> res_o.align_fault && !res_o.vec_wr)
      else $error("misaligned widen not faulted");
   a_min_search_low: assert property (
      s_req(SRD_HORIZONTAL_MIN_SEARCH) |=> res_o.vec[15:0] <= $past(req_i.b[15:0])
      && res_o.vec[127:19] == '0)
      else $error("minimum search result wrong");
   a_packed_mask_test_flags: assert property (
      s_req(SRD_PACKED_MASK_TEST) |=> res_o.flag_wr && !res_o.vec_wr
      && res_o.zero_flag == ($past(req_i.a & req_i.b) == '0))
      else $error("packed test flags wrong");
   a_pack_sat_neg: assert property (
      s_req(SRD_PACK_DWORD_WORD_UNSIGNED_SAT) && req_i.a[31] |=> res_o.vec[15:0] == 16'h0000)
      else $error("negative dword not clamped");

   c_round_inexact: cover property (s_req(SRD_ROUND_PACKED_SINGLE) ##1 res_o.inexact);
   c_abs_diff: cover property (s_req(SRD_MULTI_OFFSET_ABS_DIFF_SUM) && req_i.imm[SRD_IMM_DOFF]);
   c_min_tie: cover property (s_req(SRD_HORIZONTAL_MIN_SEARCH) && req_i.b[15:0] == req_i.b[31:16]);
   c_align_fault: cover property (res_o.align_fault);
endmodule : srd_simd_datapath

// *** shared/srd_pkg.sv ***
// Contract
// - immediate picks round mode or current mode
// - immediate bit suppresses inexact precision signal
// - round packed/scalar, single and double
// - insert/extract memory unaligned unless checking on
// - float extract any dword to register/memory
// - float insert from memory or source element
// - float insert mask forces lanes to +0
// - int insert byte/dword/qword from register/memory
// - int extract byte/word/dword/qword to register/memory
// - widen zero/sign extend into vector register
// - widen memory faults when misaligned, checking on
// - widen element counts per size pair
// - eight 16-bit four-byte absolute difference sums
// - two immediate bits select source field
// - eleven destination bytes from byte 0/4
// - minimum of eight words plus position, low dword
// - zero_flag when destination AND mask zero
// - carry_flag from inverted mask, destination untouched
// - qword equality compare like dword compare
// - pack signed dwords to words, unsigned saturation
package srd_pkg;
   localparam int SRD_VW = 128;
   localparam int SRD_SW = 64;
   // immediate field positions
   localparam int SRD_IMM_CUR = 2;
   localparam int SRD_IMM_QUIET = 3;
   localparam int SRD_IMM_DOFF = 2;
   localparam int SRD_IMM_DST = 4;
   localparam int SRD_IMM_SRC = 6;
   localparam int SRD_MIN_POS = 16;
   localparam logic [1:0] SRD_RM_NEAR = 2'h0;
   localparam logic [1:0] SRD_RM_DOWN = 2'h1;
   localparam logic [1:0] SRD_RM_UP = 2'h2;
   localparam logic [1:0] SRD_RM_TRUNC = 2'h3;
   localparam logic [1:0] SRD_SZ_B = 2'h0;
   localparam logic [1:0] SRD_SZ_W = 2'h1;
   localparam logic [1:0] SRD_SZ_D = 2'h2;
   localparam logic [1:0] SRD_SZ_Q = 2'h3;
   localparam logic [15:0] SRD_SAT_MAX = 16'hFFFF;

   typedef enum logic [3:0] {
      SRD_ROUND_PACKED_SINGLE = 4'h0,
      SRD_ROUND_PACKED_DOUBLE = 4'h1,
      SRD_ROUND_SCALAR_SINGLE = 4'h2,
      SRD_ROUND_SCALAR_DOUBLE = 4'h3,
      SRD_EXTRACT_SINGLE_FLOAT = 4'h4,
      SRD_INSERT_SINGLE_FLOAT = 4'h5,
      SRD_INSERT_INT = 4'h6,
      SRD_EXTRACT_INT = 4'h7,
      SRD_WIDEN = 4'h8,
      SRD_MULTI_OFFSET_ABS_DIFF_SUM = 4'h9,
      SRD_HORIZONTAL_MIN_SEARCH = 4'hA,
      SRD_PACKED_MASK_TEST = 4'hB,
      SRD_QWORD_EQUALITY_COMPARE = 4'hC,
      SRD_DWORD_EQUALITY_COMPARE = 4'hD,
      SRD_PACK_DWORD_WORD_UNSIGNED_SAT = 4'hE
   } srd_op_e;

   typedef struct packed {
      logic valid;
      srd_op_e op;
      logic [7:0] imm;
      logic [1:0] esz;
      logic [1:0] dsz;
      logic sext;
      logic mem;
      logic [3:0] addr_lo;
      logic [SRD_VW-1:0] a;
      logic [SRD_VW-1:0] b;
      logic [SRD_SW-1:0] scl;
   } srd_req_s;

   typedef struct packed {
      logic valid;
      logic [SRD_VW-1:0] vec;
      logic vec_wr;
      logic [SRD_SW-1:0] scl;
      logic gpr_wr;
      logic mem_wr;
      logic flag_wr;
      logic zero_flag;
      logic carry_flag;
      logic inexact;
      logic align_fault;
   } srd_res_s;
endpackage : srd_pkg

// *** logic/srd_round_lane.sv ***
`timescale 1ns/100ps
module srd_round_lane import srd_pkg::*; #(
   parameter int EW = 8,
   parameter int MW = 23
) (
   // operand and mode
   input wire logic [EW+MW:0] opnd_i,
   input wire logic [1:0] mode_i,
   // rounded value
   output logic [EW+MW:0] res_o,
   output logic inexact_o
);
   localparam int BIAS = (1 << (EW - 1)) - 1;
   logic sgn;
   logic [EW-1:0] ex;
   logic [MW-1:0] mn;
   logic [MW-1:0] mask;
   logic half;
   logic stk;
   logic lsb;
   logic up;
   int e;

   always_comb begin
      sgn = opnd_i[EW+MW];
      ex = opnd_i[EW+MW-1:MW];
      mn = opnd_i[MW-1:0];
      e = int'(ex) - BIAS;
      mask = '0;
      half = 1'b0;
      stk = 1'b0;
      lsb = 1'b0;
      if (ex == {EW{1'b1}} || e >= MW) begin
      end else if (e < 0) begin
         half = (e == -1);
         stk = (e == -1) ? (mn != '0) : (ex != '0 || mn != '0);
      end else begin
         mask = {MW{1'b1}} >> e;
         lsb = (e == 0) ? 1'b1 : mn[MW-e];
         half = mn[MW-1-e];
         stk = |(mn & (mask >> 1));
      end
      unique case (mode_i)
         SRD_RM_NEAR: up = half & (stk | lsb);
         SRD_RM_DOWN: up = sgn & (half | stk);
         SRD_RM_UP: up = ~sgn & (half | stk);
         default: up = 1'b0;
      endcase
      res_o = opnd_i;
      if (ex == {EW{1'b1}}) begin
         if (mn != '0) res_o[MW-1] = 1'b1;
      end else if (e < 0) begin
         res_o = {sgn, up ? EW'(BIAS) : {EW{1'b0}}, {MW{1'b0}}};
      end else if (e < MW) begin
         res_o[EW+MW-1:0] = ({ex, mn} & ~{{EW{1'b0}}, mask})
            + (up ? ((EW+MW)'(1) << (MW - e)) : {(EW+MW){1'b0}});
      end
      inexact_o = half | stk;
   end
endmodule : srd_round_lane

// *** verification/tb_srd_simd_datapath.sv ***
`timescale 1ns/100ps
module tb_srd_simd_datapath import srd_pkg::*; ;
   logic mclk_i = 1'h0;
   logic rst_i = 1'h1;
   logic [1:0] cur_round_mode_i = 2'h0;
   logic align_check_i = 1'h0;
   srd_req_s req_i = '0;
   srd_res_s res_o;
   int err_count = 0;
   int check_count = 0;
   int cyc = 0;
   srd_req_s q;
   logic [1:0] cm = 2'h0;
   logic ac = 1'h0;
   logic [127:0] a;
   logic [127:0] e;
   logic [63:0] x;
   logic [63:0] m;
   logic f;
   int w;
   int n;
   int k;

   srd_simd_datapath srd_simd_datapath_i (.mclk_i(mclk_i), .rst_i(rst_i), .cur_round_mode_i(cur_round_mode_i),
      .align_check_i(align_check_i), .req_i(req_i), .res_o(res_o));

   initial begin
      forever #10 mclk_i = ~mclk_i;
   end

   task automatic chk(input logic [127:0] got, input logic [127:0] exp);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : end_of_test

   always @(posedge mclk_i) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         err_count++;
         end_of_test();
      end
   end

   task automatic fin(input string s);
      $display("test %s done", s);
   endtask : fin

   task automatic setq(input srd_op_e op, input logic [7:0] imm, input logic [127:0] va, input logic [127:0] vb);
      q = '0;
      q.op = op;
      q.imm = imm;
      q.a = va;
      q.b = vb;
      e = '0;
   endtask : setq

   // one request, result sampled after the answering edge
   task automatic go();
      q.valid = 1'h1;
      @(posedge mclk_i);
      req_i <= q;
      cur_round_mode_i <= cm;
      align_check_i <= ac;
      @(posedge mclk_i);
      req_i.valid <= 1'h0;
      #1;
      chk(res_o.valid, 1'h1);
   endtask : go

   function automatic logic [127:0] r128();
      return {$urandom, $urandom, $urandom, $urandom};
   endfunction : r128

   // k: 0 gives 2.0, 1 gives 2.5, 2 gives 3.0
   function automatic logic [63:0] fl(logic d, logic s, int k);
      return d ? {s, 15'h4000 + 15'(4 * k), 48'h0} : {32'h0, s, 15'h4000 + 15'(32 * k), 16'h0};
   endfunction : fl

   function automatic logic [127:0] wid(logic [127:0] b, int s, int d, logic sx);
      int sw;
      int dw;
      wid = '0;
      sw = 8 << s;
      dw = 8 << d;
      for (int i = 0; i < (16 >> d); i++) begin
         for (int j = 0; j < dw; j++) begin
            wid[dw * i + j] = (j < sw) ? b[sw * i + j] : sx & b[sw * i + sw - 1];
         end
      end
   endfunction : wid

   function automatic logic [127:0] sad(logic [127:0] va, logic [127:0] vb, logic [2:0] md);
      int s;
      int u;
      int v;
      sad = '0;
      for (int i = 0; i < 8; i++) begin
         s = 0;
         for (int j = 0; j < 4; j++) begin
            u = va[8 * (4 * md[2] + i + j) +: 8];
            v = vb[8 * (4 * md[1:0] + j) +: 8];
            s += u > v ? u - v : v - u;
         end
         sad[16 * i +: 16] = 16'(s);
      end
   endfunction : sad

   function automatic logic [127:0] hmin(logic [127:0] b);
      int p;
      p = 0;
      for (int i = 1; i < 8; i++) begin
         if (b[16 * i +: 16] < b[16 * p +: 16]) p = i;
      end
      return {109'h0, 3'(p), b[16 * p +: 16]};
   endfunction : hmin

   function automatic logic [127:0] eqv(logic [127:0] va, logic [127:0] vb, int lw);
      logic [127:0] t;
      for (int i = 0; i < 128; i++) begin
         t = (va ^ vb) >> (i / lw * lw) << (128 - lw);
         eqv[i] = t == '0;
      end
   endfunction : eqv

   function automatic logic [15:0] sat(logic [31:0] d);
      if (d[31]) return 16'h0000;
      if (d[30:16] != 15'h0) return 16'hFFFF;
      return d[15:0];
   endfunction : sat

   initial begin
      void'($urandom(96));
      repeat (3) @(posedge mclk_i);
      rst_i <= 1'h0;
      #1;
      chk({res_o.valid, res_o.vec[126:0]}, '0);
      // +2.5 and -2.5 lanes, every mode, immediate or stored
      for (int op = 0; op < 4; op++) begin
         for (int i = 0; i < 16; i++) begin
            w = op[0] ? 64 : 32;
            a = r128();
            setq(srd_op_e'(op[3:0]), {4'h0, i[3:2], i[1:0] ^ {2{i[2]}}}, a, '0);
            cm = i[1:0] ^ {2{~i[2]}};
            for (int j = 0; j < 128 / w; j++) begin
               q.b |= 128'(fl(op[0], j[0], 1)) << (w * j);
               k = (j[0] ? i[1:0] == SRD_RM_DOWN : i[1:0] == SRD_RM_UP) ? 2 : 0;
               e |= 128'(fl(op[0], j[0], k)) << (w * j);
            end
            if (op[1]) e = (a >> w << w) | (e << (128 - w) >> (128 - w));
            go();
            chk(res_o.vec, e);
            chk(res_o.inexact, !i[3]);
         end
      end
      @(posedge mclk_i);
      #1;
      chk({res_o.valid, res_o.vec_wr}, 2'h0);
      fin("round");
      for (int s = 0; s < 3; s++) begin
         for (int d = s + 1; d < 4; d++) begin
            for (int i = 0; i < 16; i++) begin
               setq(SRD_WIDEN, 8'h0, r128(), r128());
               q.esz = 2'(s);
               q.dsz = 2'(d);
               q.sext = i[0];
               q.mem = i[1];
               q.addr_lo = 4'($urandom);
               q.scl = {$urandom, $urandom};
               ac = i[2];
               n = (16 >> d) << s;
               k = q.mem && ac && q.addr_lo % n != 0;
               go();
               chk(res_o.vec, wid(q.mem ? 128'(q.scl) : q.b, s, d, i[0]));
               chk(res_o.align_fault, k);
               chk(res_o.vec_wr, !k);
            end
         end
      end
      ac = 1'h0;
      fin("widen");
      for (int i = 0; i < 24; i++) begin
         setq(SRD_MULTI_OFFSET_ABS_DIFF_SUM, 8'(i % 8), r128(), r128());
         if (i > 15) begin
            q.a = '1;
            q.b = '0;
         end
         go();
         chk(res_o.vec, sad(q.a, q.b, i[2:0]));
      end
      fin("abs diff");
      for (int i = 0; i < 20; i++) begin
         setq(SRD_HORIZONTAL_MIN_SEARCH, 8'h0, r128(), r128());
         for (int j = 0; j < 8; j++) begin
            if (i[0]) q.b[16 * j +: 16] = 16'($urandom % 3);
         end
         go();
         chk(res_o.vec, hmin(q.b));
      end
      fin("min search");
      for (int i = 0; i < 12; i++) begin
         a = (i == 11) ? '0 : r128();
         setq(SRD_PACKED_MASK_TEST, 8'h0, a, i % 3 == 0 ? ~a : i % 3 == 1 ? a | r128() : r128());
         go();
         chk(res_o.zero_flag, (q.a & q.b) == '0);
         chk(res_o.carry_flag, (q.a & ~q.b) == '0);
         chk({res_o.vec_wr, res_o.flag_wr}, 2'h1);
      end
      fin("mask test");
      for (int i = 0; i < 16; i++) begin
         a = r128();
         setq(i[0] ? SRD_QWORD_EQUALITY_COMPARE : SRD_DWORD_EQUALITY_COMPARE, 8'h0, a, a);
         q.b ^= (128'(i[1]) << ($urandom % 128)) | (128'(i[2]) << ($urandom % 128));
         go();
         chk(res_o.vec, eqv(q.a, q.b, i[0] ? 64 : 32));
      end
      fin("equality");
      for (int i = 0; i < 12; i++) begin
         setq(SRD_PACK_DWORD_WORD_UNSIGNED_SAT, 8'h0, r128(), r128() >> (i % 4 * 8));
         if (i == 0) q.a = {32'h80000000, 32'hFFFFFFFF, 32'h0000FFFF, 32'h00010000};
         if (i == 1) q.b = {32'h7FFFFFFF, 32'h00000000, 32'h00001234, 32'hFFFF0000};
         for (int j = 0; j < 4; j++) begin
            e[16 * j +: 16] = sat(q.a[32 * j +: 32]);
            e[64 + 16 * j +: 16] = sat(q.b[32 * j +: 32]);
         end
         go();
         chk(res_o.vec, e);
      end
      fin("pack");
      for (int i = 0; i < 32; i++) begin
         k = i % 4;
         if (i[2] && k == 1) continue;
         w = 8 << k;
         n = $urandom % 16;
         a = r128();
         x = {$urandom, $urandom};
         setq(i[2] ? SRD_INSERT_INT : SRD_EXTRACT_INT, 8'(n), a, a);
         q.esz = 2'(k);
         q.mem = i[3];
         q.scl = x;
         q.addr_lo = 4'($urandom);
         ac = i[4];
         f = q.mem && ac && q.addr_lo % (1 << k) != 0;
         go();
         n = n % (16 >> k);
         m = (64'h1 << w) - 64'h1;
         chk(res_o.align_fault, f);
         if (i[2]) begin
            chk(res_o.vec, (a & ~(128'(m) << (w * n))) | (128'(x & m) << (w * n)));
         end else begin
            chk(res_o.scl, 64'(a >> (w * n)) & m);
            chk({res_o.gpr_wr, res_o.mem_wr}, {~q.mem, q.mem} & {2{!f}});
         end
      end
      ac = 1'h0;
      fin("int insert extract");
      for (int i = 0; i < 24; i++) begin
         a = r128();
         setq(i[0] ? SRD_INSERT_SINGLE_FLOAT : SRD_EXTRACT_SINGLE_FLOAT, 8'($urandom), a, i[0] ? r128() : a);
         q.mem = i[1];
         q.scl = {$urandom, $urandom};
         go();
         if (i[0]) begin
            e = a;
            e[32 * q.imm[5:4] +: 32] = q.mem ? q.scl[31:0] : q.b[32 * q.imm[7:6] +: 32];
            for (int j = 0; j < 4; j++) begin
               if (q.imm[j]) e[32 * j +: 32] = '0;
            end
            chk(res_o.vec, e);
         end else begin
            chk(res_o.scl, a[32 * q.imm[1:0] +: 32]);
            chk({res_o.gpr_wr, res_o.mem_wr}, {~q.mem, q.mem});
         end
      end
      fin("float insert extract");
      end_of_test();
   end
endmodule : tb_srd_simd_datapath
